// ### inc/stp_pkg.sv
package stp_pkg;

	// scan chain lengths
	localparam int IR_LEN   = 3;
	localparam int BSR_LEN  = 109;
	localparam int ID_LEN   = 32;
	// boundary cell that gates the read-data drivers
	localparam int BSR_OE_CELL = 108;

	// instruction codes
	localparam logic [2:0] INS_EXTEST   = 3'h0;
	localparam logic [2:0] INS_IDCODE   = 3'h1;
	localparam logic [2:0] INS_SAMPLEZ  = 3'h2;
	localparam logic [2:0] INS_PRELOAD  = 3'h4;
	localparam logic [2:0] INS_BYPASS   = 3'h7;
	// value captured into the instruction shifter (low bits 01)
	localparam logic [2:0] IR_CAPTURE   = 3'h1;

	// identification field positions
	localparam int ID_VER_LSB  = 29;
	localparam int ID_PART_LSB = 12;
	localparam int ID_MFR_LSB  = 1;

	// link timing: tdo valid after tck fall, max link rate
	localparam int TDO_VALID_NS = 10;
	localparam int TCK_MAX_MHZ  = 20;
	localparam int CORE_MHZ     = 200;

	// controller states
	typedef enum logic [3:0] {
		STP_RESET      = 4'h0,
		STP_IDLE       = 4'h1,
		STP_SEL_DR     = 4'h2,
		STP_CAP_DR     = 4'h3,
		STP_SHIFT_DR   = 4'h4,
		STP_EXIT1_DR   = 4'h5,
		STP_PAUSE_DR   = 4'h6,
		STP_EXIT2_DR   = 4'h7,
		STP_UPD_DR     = 4'h8,
		STP_SEL_IR     = 4'h9,
		STP_CAP_IR     = 4'hA,
		STP_SHIFT_IR   = 4'hB,
		STP_EXIT1_IR   = 4'hC,
		STP_PAUSE_IR   = 4'hD,
		STP_EXIT2_IR   = 4'hE,
		STP_UPD_IR     = 4'hF
	} stp_state_t;

endpackage

// ### rtl/stp_sync2.sv
`timescale 1ns/100ps
module stp_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,     // destination clock
	input  wire logic [W-1:0] d_in,    // asynchronous level
	output logic      [W-1:0] q_out    // synchronised level
);
	logic [W-1:0] meta_r;

	// two-stage level synchroniser
	always_ff @(posedge clk)
	begin
		meta_r <= d_in;
		q_out  <= meta_r;
	end
endmodule // stp_sync2

// ### rtl/stp_fsm.sv
`timescale 1ns/100ps
module stp_fsm (
	input  wire logic              tck,       // link clock
	input  wire logic              trst_n,    // sync reset in tck domain, active low
	input  wire logic              tms,       // mode select
	output stp_pkg::stp_state_t    state      // current controller state
);
	import stp_pkg::*;

	stp_state_t state_nxt;

	// RULE16: sixteen-state walk
	always_comb
	begin
		case (state)
			STP_RESET:    state_nxt = tms ? STP_RESET    : STP_IDLE;
			STP_IDLE:     state_nxt = tms ? STP_SEL_DR   : STP_IDLE;
			STP_SEL_DR:   state_nxt = tms ? STP_SEL_IR   : STP_CAP_DR;
			STP_CAP_DR:   state_nxt = tms ? STP_EXIT1_DR : STP_SHIFT_DR;
			STP_SHIFT_DR: state_nxt = tms ? STP_EXIT1_DR : STP_SHIFT_DR;
			STP_EXIT1_DR: state_nxt = tms ? STP_UPD_DR   : STP_PAUSE_DR;
			STP_PAUSE_DR: state_nxt = tms ? STP_EXIT2_DR : STP_PAUSE_DR;
			STP_EXIT2_DR: state_nxt = tms ? STP_UPD_DR   : STP_SHIFT_DR;
			STP_UPD_DR:   state_nxt = tms ? STP_SEL_DR   : STP_IDLE;
			STP_SEL_IR:   state_nxt = tms ? STP_RESET    : STP_CAP_IR;
			STP_CAP_IR:   state_nxt = tms ? STP_EXIT1_IR : STP_SHIFT_IR;
			STP_SHIFT_IR: state_nxt = tms ? STP_EXIT1_IR : STP_SHIFT_IR;
			STP_EXIT1_IR: state_nxt = tms ? STP_UPD_IR   : STP_PAUSE_IR;
			STP_PAUSE_IR: state_nxt = tms ? STP_EXIT2_IR : STP_PAUSE_IR;
			STP_EXIT2_IR: state_nxt = tms ? STP_UPD_IR   : STP_SHIFT_IR;
			STP_UPD_IR:   state_nxt = tms ? STP_SEL_DR   : STP_IDLE;
			default:      state_nxt = STP_RESET;
		endcase
	end

	// state register, advanced on rising tck
	always_ff @(posedge tck)
	begin
		if (!trst_n)
			state <= STP_RESET;
		else
			state <= state_nxt;
	end
endmodule // stp_fsm

// ### rtl/stp_tap.sv
// Functional notes
// RULE1: chains are 3-bit instruction, 1-bit bypass, 32-bit id, 109-cell boundary.
// RULE2: code 000 is extest; capture ring contents, drive preloaded outputs.
// RULE3: code 001 is idcode; id register sits between tdi and tdo.
// RULE4: code 010 captures pins, selects boundary chain, floats all output drivers.
// RULE5: code 100 is sample/preload; capture, shift boundary chain, core unaffected.
// RULE6: controller never loads reserved codes 011, 101, 110; the code loads them into ir_cur_r and routes them to bypass.
// RULE7: code 111 selects one-bit bypass, core unaffected.
// RULE8: id bits 31:29 version, 28:12 part type, hardwired.
// RULE9: id bits 11:1 hold a hardwired maker code.
// RULE10: id bit 0 always reads one.
// RULE11: tdo changes only after tck falls, valid within 10 ns.
// RULE12: tms and tdi sampled on rising tck; tck at most 20 MHz.
// RULE13: idcode becomes current at power-up and in test-logic-reset.
// RULE14: cell 108 gates read drivers in extest; preset high on reset.
// RULE15: boundary msb connects to tdi, cell zero to tdo.
// RULE16: sixteen-state controller on tms; data shifts lsb first toward tdo.
`timescale 1ns/100ps
module stp_tap
	import stp_pkg::*;
#(
	parameter int                 BSR_W    = stp_pkg::BSR_LEN,
	parameter logic [2:0]         ID_VER   = 3'h5,          // arbitrary value
	parameter logic [16:0]        ID_PART  = 17'h0ABCD,     // arbitrary value
	parameter logic [10:0]        ID_MFR   = 11'h2A5        // arbitrary value
) (
	input  wire logic             core_clk,       // core clock, 200 MHz
	input  wire logic             resetn,         // sync reset, active low, core domain
	input  wire logic             tck,            // link clock from test controller
	input  wire logic             tms,            // mode select, sampled on rising tck
	input  wire logic             tdi,            // serial data in
	output logic                  tdo,            // serial data out
	output logic                  tdo_oe,         // tdo driven while shifting
	input  wire logic [BSR_W-2:0] pin_capture,    // live pin values for cells 0..107
	output logic [BSR_W-2:0]      pin_drive,      // preloaded values for extest drive
	output logic                  extest_active,  // core: pins follow boundary latch
	output logic                  q_bus_oe        // read-data drivers enabled (core clock)
);
	import stp_pkg::*;

	stp_state_t         state;
	logic               trst_n;
	// RULE1: the four scan chains
	logic [IR_LEN-1:0]  ir_shift_r;
	logic [IR_LEN-1:0]  ir_cur_r;
	logic               bypass_r;
	logic [ID_LEN-1:0]  id_shift_r;
	logic [BSR_W-1:0]   bsr_shift_r;
	logic [BSR_W-1:0]   bsr_upd_r;
	logic               serial_out;
	logic               shifting;
	logic               oe_link_r;
	logic               oe_sync;
	logic [BSR_W-2:0]   pin_sync;
	logic [BSR_W-1:0]   bsr_capture;
	logic [ID_LEN-1:0]  id_value;
	logic               rst_meta_r;
	logic               rst_link_r;

	// core reset carried into the link domain (level, two flops)
	always_ff @(posedge tck)
	begin
		rst_meta_r <= resetn;
		rst_link_r <= rst_meta_r;
	end
	assign trst_n = rst_link_r;

	// RULE12: tms taken on rising tck
	// RULE16: controller state machine
	stp_fsm u_fsm (
		.tck    (tck),
		.trst_n (trst_n),
		.tms    (tms),
		.state  (state)
	);

	// RULE8: hardwired id fields
	// RULE9: maker code field
	// RULE10: presence bit
	assign id_value = {ID_VER, ID_PART, ID_MFR, 1'b1};

	// live pins cross into the link domain before any capture reads them
	stp_sync2 #(
		.W (BSR_W - 1)
	) u_pin_sync (
		.clk   (tck),
		.d_in  (pin_capture),
		.q_out (pin_sync)
	);

	// boundary capture: pins plus the internal gate cell's own latch
	assign bsr_capture = {bsr_upd_r[BSR_OE_CELL], pin_sync};

	// instruction shifter and current instruction
	always_ff @(posedge tck)
	begin
		if (!trst_n)
		begin
			ir_shift_r <= INS_IDCODE;
			ir_cur_r   <= INS_IDCODE;
		end
		// RULE13: idcode on test-logic-reset
		else if (state == STP_RESET)
		begin
			ir_shift_r <= INS_IDCODE;
			ir_cur_r   <= INS_IDCODE;
		end
		else
		begin
			case (state)
				STP_CAP_IR:   ir_shift_r <= IR_CAPTURE;
				STP_SHIFT_IR: ir_shift_r <= {tdi, ir_shift_r[IR_LEN-1:1]};
				// RULE6: reserved codes are not expected here
				STP_UPD_IR:   ir_cur_r <= ir_shift_r;
				default:      ir_shift_r <= ir_shift_r;
			endcase
		end
	end

	// RULE7: bypass bit
	always_ff @(posedge tck)
	begin
		if (!trst_n)
			bypass_r <= 1'b0;
		else if (state == STP_CAP_DR)
			bypass_r <= 1'b0;
		else if (state == STP_SHIFT_DR)
			bypass_r <= tdi;    // reserved codes route through this bit too
	end

	// RULE3: id register capture and shift
	always_ff @(posedge tck)
	begin
		if (!trst_n)
			id_shift_r <= '0;
		else if (ir_cur_r == INS_IDCODE && state == STP_CAP_DR)
			id_shift_r <= id_value;
		else if (ir_cur_r == INS_IDCODE && state == STP_SHIFT_DR)
			id_shift_r <= {tdi, id_shift_r[ID_LEN-1:1]};
	end

	// boundary shift stage for codes 000, 010 and 100
	always_ff @(posedge tck)
	begin
		if (!trst_n)
			bsr_shift_r <= '0;
		else if (ir_cur_r == INS_EXTEST || ir_cur_r == INS_SAMPLEZ || ir_cur_r == INS_PRELOAD)
		begin
			// RULE2: extest capture
			// RULE5: sample capture
			if (state == STP_CAP_DR)
				bsr_shift_r <= bsr_capture;
			// RULE15: tdi enters msb, cell zero leaves
			else if (state == STP_SHIFT_DR)
				bsr_shift_r <= {tdi, bsr_shift_r[BSR_W-1:1]};
		end
	end

	// boundary update latch
	always_ff @(posedge tck)
	begin
		// RULE14: gate cell preset high
		if (!trst_n || state == STP_RESET)
		begin
			bsr_upd_r              <= '0;
			bsr_upd_r[BSR_OE_CELL] <= 1'b1;
		end
		else if (state == STP_UPD_DR &&
			(ir_cur_r == INS_EXTEST || ir_cur_r == INS_SAMPLEZ || ir_cur_r == INS_PRELOAD))
			bsr_upd_r <= bsr_shift_r;
	end

	// serial output select by instruction and shift phase
	always_comb
	begin
		shifting   = (state == STP_SHIFT_DR) || (state == STP_SHIFT_IR);
		serial_out = 1'b0;
		if (state == STP_SHIFT_IR)
			serial_out = ir_shift_r[0];
		else
		begin
			case (ir_cur_r)
				INS_IDCODE:  serial_out = id_shift_r[0];
				INS_EXTEST,
				INS_SAMPLEZ,
				INS_PRELOAD: serial_out = bsr_shift_r[0];
				default:     serial_out = bypass_r;
			endcase
		end
	end

	// RULE11: tdo updated on falling tck only
	always_ff @(negedge tck)
	begin
		if (!trst_n)
		begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end
		else
		begin
			tdo    <= serial_out;
			tdo_oe <= shifting;
		end
	end

	// driver enable, registered at the edge that changes its sources so the crossing sees no glitch
	always_ff @(posedge tck)
	begin
		if (!trst_n || state == STP_RESET)
			oe_link_r <= 1'b1;
		else if (state == STP_UPD_IR)
		begin
			case (ir_shift_r)
				// RULE4: sample-z floats the output drivers
				INS_SAMPLEZ: oe_link_r <= 1'b0;
				// RULE14: gate cell controls drivers in extest
				INS_EXTEST:  oe_link_r <= bsr_upd_r[BSR_OE_CELL];
				default:     oe_link_r <= 1'b1;
			endcase
		end
		// RULE14: new gate value latched while in extest
		else if (state == STP_UPD_DR && ir_cur_r == INS_EXTEST)
			oe_link_r <= bsr_shift_r[BSR_OE_CELL];
	end

	// preloaded pin values, held stable in the link domain
	assign pin_drive = bsr_upd_r[BSR_W-2:0];

	// RULE2: extest hands pins to the boundary latch
	always_ff @(posedge tck)
	begin
		if (!trst_n || state == STP_RESET)
			extest_active <= 1'b0;
		else if (state == STP_UPD_IR)
			extest_active <= (ir_shift_r == INS_EXTEST);
	end

	// driver enable crosses into the core domain
	stp_sync2 #(
		.W (1)
	) u_oe_sync (
		.clk   (core_clk),
		.d_in  (oe_link_r),
		.q_out (oe_sync)
	);

	// registered core-side enable
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			q_bus_oe <= 1'b1;
		else
			q_bus_oe <= oe_sync;
	end
endmodule // stp_tap

// ### verification/stp_ctrl_model.sv
`timescale 1ns/100ps
module stp_ctrl_model (
	output logic     tck, // link clock
	output logic     tms, // mode
	output logic     tdi, // data in
	input wire logic tdo  // data out
);
	// link idles low between frames
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// change after fall, sample at rise
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#80 tck = 1'b1;
		o = tdo;
		#80 tck = 1'b0;
	endtask
	// walk from idle, lsb first, implemented codes only
	task automatic shift(input int n, input logic [108:0] din, input logic ir, output logic [108:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b0, o);
		if (ir)
			step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
		step(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b0, o);
		step(1'b0, 1'b0, o);
	endtask
endmodule // stp_ctrl_model

// ### verification/stp_tap_properties.sv
`timescale 1ns/100ps
module stp_tap_properties #(
	parameter int BSR_W = 109
) (
	input wire logic             core_clk,      // core clock
	input wire logic             resetn,        // reset
	input wire logic             tck,           // link clock
	input wire logic             tms,           // mode
	input wire logic             tdo,           // data out
	input wire logic             tdo_oe,        // out enable
	input wire logic [BSR_W-2:0] pin_drive,     // update latch
	input wire logic             extest_active, // extest
	input wire logic             q_bus_oe       // read drivers
);
	// reset values on both sides
	property p_qoe_rst;
		@(posedge core_clk) disable iff (!resetn) $rose(resetn) |-> q_bus_oe;
	endproperty
	a_qoe_rst: assert property (p_qoe_rst) else $error("drivers off after reset");
	property p_tck_rst;
		@(posedge tck) disable iff (!resetn) $rose(resetn) |-> !extest_active && !tdo_oe && pin_drive == '0;
	endproperty
	a_tck_rst: assert property (p_tck_rst) else $error("link outputs not reset");
	// serial outputs move only while tck is low
	property p_tdo_fall;
		@(posedge core_clk) disable iff (!resetn) tck && $past(tck) |-> $stable(tdo);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved with tck high");
	property p_oe_fall;
		@(posedge core_clk) disable iff (!resetn) tck && $past(tck) |-> $stable(tdo_oe);
	endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("tdo_oe moved with tck high");
	// update outputs move only on rising tck
	property p_pd_rise;
		@(posedge core_clk) disable iff (!resetn) !tck && !$past(tck) |-> $stable(pin_drive);
	endproperty
	a_pd_rise: assert property (p_pd_rise) else $error("pin_drive moved with tck low");
	property p_ext_rise;
		@(posedge core_clk) disable iff (!resetn) !tck && !$past(tck) |-> $stable(extest_active);
	endproperty
	a_ext_rise: assert property (p_ext_rise) else $error("extest moved with tck low");
	// tms held high forces test-logic-reset
	property p_tlr;
		@(posedge tck) disable iff (!resetn) tms[*7] |=> !extest_active && pin_drive == '0;
	endproperty
	a_tlr: assert property (p_tlr) else $error("tms reset left extest");
	property p_tlr_oe;
		@(posedge tck) disable iff (!resetn) tms[*8] |=> q_bus_oe;
	endproperty
	a_tlr_oe: assert property (p_tlr_oe) else $error("tms reset left drivers off");
endmodule // stp_tap_properties
bind stp_tap stp_tap_properties #(.BSR_W(BSR_W)) props_u (.core_clk(core_clk), .resetn(resetn), .tck(tck),
	.tms(tms), .tdo(tdo), .tdo_oe(tdo_oe), .pin_drive(pin_drive), .extest_active(extest_active),
	.q_bus_oe(q_bus_oe));

// ### verification/stp_tap_tb_top.sv
`timescale 1ns/100ps
module stp_tap_tb_top;
	import stp_pkg::*;
	localparam logic [31:0]  T_ID = {3'h3, 17'h1234B, 11'h155, 1'b1}; // arbitrary value
	localparam logic [107:0] P    = {9{12'hC35}};
	localparam logic [108:0] D    = {1'b0, {9{12'h5A3}}};
	logic         core_clk = 1'b0, resetn, tck, tms, tdi, tdo, tdo_oe, extest_active, q_bus_oe, c108, o;
	logic [107:0] pin_capture, pin_drive;
	logic [108:0] dout;
	logic [2:0]   codes [4] = '{INS_PRELOAD, INS_SAMPLEZ, INS_BYPASS, INS_EXTEST};
	int           mismatches = 0, n_compared = 0;
	// core clock
	always #2.5 core_clk = ~core_clk;
	stp_tap #(.ID_VER(T_ID[31:29]), .ID_PART(T_ID[28:12]), .ID_MFR(T_ID[11:1])) dut_u (.core_clk(core_clk),
		.resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_capture(pin_capture),
		.pin_drive(pin_drive), .extest_active(extest_active), .q_bus_oe(q_bus_oe));
	stp_ctrl_model ctl_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	// compare and count
	task automatic chk(input logic [108:0] exp, input logic [108:0] got, input string nm);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic read_id();
		ctl_u.shift(32, '0, 1'b0, dout);
		chk(109'(T_ID), dout, "idcode");
	endtask
	// main sequence
	initial
	begin
		resetn = 1'b0;
		pin_capture = P;
		#1.3;
		repeat (4) ctl_u.step(1'b1, 1'b0, o);
		@(negedge core_clk) resetn = 1'b1;
		repeat (4) ctl_u.step(1'b1, 1'b0, o);
		ctl_u.step(1'b0, 1'b0, o);
		read_id();
		// output enable follows the shift states, looked at mid low phase
		ctl_u.step(1'b1, 1'b0, o);
		ctl_u.step(1'b0, 1'b0, o);
		ctl_u.step(1'b0, 1'b0, o);
		#40;
		chk(109'h1, 109'(tdo_oe), "tdo_oe shift");
		ctl_u.step(1'b1, 1'b0, o);
		#40;
		chk(109'h0, 109'(tdo_oe), "tdo_oe exit");
		ctl_u.step(1'b1, 1'b0, o);
		ctl_u.step(1'b0, 1'b0, o);
		c108 = 1'b1;
		foreach (codes[k])
		begin
			ctl_u.shift(3, 109'(codes[k]), 1'b1, dout);
			chk(109'(IR_CAPTURE), dout, "ir capture");
			if (codes[k] == INS_BYPASS)
			begin
				ctl_u.shift(2, 109'h1, 1'b0, dout);
				chk(109'h2, dout, "bypass");
			end
			else
			begin
				ctl_u.shift(109, D, 1'b0, dout);
				chk({c108, P}, dout, "boundary");
				chk(109'(D[107:0]), 109'(pin_drive), "pin_drive");
				c108 = D[108];
			end
			chk(109'(codes[k] == INS_EXTEST), 109'(extest_active), "extest");
			chk(109'(codes[k] == INS_PRELOAD || codes[k] == INS_BYPASS), 109'(q_bus_oe), "q_bus_oe");
		end
		// extest with the gate cell raised, then lowered again
		ctl_u.shift(109, {1'b1, D[107:0]}, 1'b0, dout);
		chk({c108, P}, dout, "boundary gate");
		chk(109'h1, 109'(q_bus_oe), "q_bus_oe gate high");
		ctl_u.shift(109, D, 1'b0, dout);
		chk({1'b1, P}, dout, "boundary gate cell");
		chk(109'h0, 109'(q_bus_oe), "q_bus_oe gate low");
		repeat (8) ctl_u.step(1'b1, 1'b0, o);
		ctl_u.step(1'b0, 1'b0, o);
		read_id();
		chk(109'h1, 109'(q_bus_oe), "q_bus_oe reset");
		chk(109'h0, 109'(pin_drive), "pin_drive reset");
		finish_test();
	end
	// watchdog
	initial
	begin
		#200000;
		mismatches++;
		finish_test();
	end
endmodule // stp_tap_tb_top
